// ===== core/bbp_pkg.sv
// Purpose: shared constants and types of the bit-bang parallel port
// Assumes: 25 MHz system clock, AXI4-Lite register access
// Notes: one instance serves one channel
package bbp_pkg;
	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BAUD = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	// control register layout
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MASK_LSB = 8;
	localparam int CTRL_PD_BIT = 16;
	// status register layout
	localparam int STAT_PIN_LSB = 0;
	localparam int STAT_OUT_LSB = 8;
	localparam int STAT_PEND_BIT = 16;
	localparam int STAT_BUSY_BIT = 17;
	// mode-select command values
	localparam logic [7:0] MODE_OFF = 8'h00;
	localparam logic [7:0] MODE_ASYNC = 8'h01;
	localparam logic [7:0] MODE_SYNC = 8'h04;
	// reset values
	localparam logic [15:0] BAUD_RST = 16'h0019;
	localparam logic [7:0] MASK_RST = 8'h00;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// wake hold: low cycles on the flush input before a wake pulse
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned WAKE_MS = 20;
	localparam int unsigned WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
	localparam int WAKE_W = 20;
	// synchronous cycle sequencer, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SAMPLE = 4'h2,
		ST_DRIVE = 4'h4,
		ST_STROBE = 4'h8
	} bbp_sst_t;
endpackage : bbp_pkg

// ===== core/bbp_tick_if.sv
// Purpose: carries the baud divisor out and the pacing tick back
// Assumes: single clock domain
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none
interface bbp_tick_if;
	logic [15:0] divisor; // cycles per tick, zero acts as one
	logic enable; // divider runs only while set
	logic tick; // one-cycle pacing pulse
	modport gen (input divisor, input enable, output tick);
	modport user (output divisor, output enable, input tick);
endinterface : bbp_tick_if
`default_nettype wire

// ===== core/bbp_baud_gen.sv
// Purpose: programmable divider giving the asynchronous pacing tick
// Assumes: divisor is stable while enabled
// Notes: period is divisor cycles, a divisor of zero behaves as one
`timescale 1ns/100ps
`default_nettype none
module bbp_baud_gen (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	bbp_tick_if.gen tif
);
	typedef struct packed {
		logic [15:0] cnt; // cycles left to next tick
		logic tick; // registered pulse
	} bbp_bg_t;
	bbp_bg_t s_r, s_nxt;

	////////////////////////////////////////////////////////////////////
	// countdown, reload on zero
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (!tif.enable) begin
			s_nxt.cnt = '0; // first tick right after enable
		end else if (s_r.cnt == '0) begin
			s_nxt.tick = 1'b1;
			s_nxt.cnt = (tif.divisor == '0) ? '0 : tif.divisor - 16'h0001;
		end else begin
			s_nxt.cnt = s_r.cnt - 16'h0001;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tif.tick = s_r.tick;
endmodule : bbp_baud_gen
`default_nettype wire

// ===== core/bbp_port.sv
// Purpose: one channel of a bit-bang parallel port fed by the host pipe
// Assumes: stream and pin inputs synchronous to CLK_SYS_I
// Notes: instantiate once per channel; settings held in CTRL and BAUD
// Operation
// - each channel sets its own bit-bang variant
// - async mode drives host bytes at tick pace
// - async outputs change only on new byte plus tick
// - async mode shows read and write strobes
// - direction mask comes only with mode-select
// - value 1 async, value 4 sync
// - sync outputs update only on taken byte
// - sync sampling happens only within write cycle
// - sync cycle starts only with to-host room
// - sync samples before driving, one byte lag
// - sample, strobe high, drive, setup, write strobe
// - read strobe rising edge marks the sample
// - write strobe asserts with the byte in async, one clock after it in sync
// - falling edge of flush input flags transfer
// - flush sends buffered data at once
// - enabled pull-down blocks wake from suspend
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module bbp_port #(
	parameter int unsigned WAKE_CYC = bbp_pkg::WAKE_CYC // low cycles to wake
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	// axi4-lite slave
	input wire logic [7:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [7:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	// from_host_fifo read side
	input wire logic [7:0] RX_DATA_I,
	input wire logic RX_VALID_I,
	output logic RX_READY_O,
	// to_host_fifo write side, ready means room
	output logic [7:0] TX_DATA_O,
	output logic TX_VALID_O,
	input wire logic TX_READY_I,
	// parallel pins
	input wire logic [7:0] PIN_I,
	output logic [7:0] PIN_O,
	output logic [7:0] PIN_OE_O,
	output logic PIN_SAMPLE_STROBE_N_O,
	output logic PIN_UPDATE_STROBE_N_O,
	// flush / wake
	input wire logic FLUSH_OR_WAKE_N_I,
	input wire logic SUSPENDED_I,
	output logic FLUSH_O,
	output logic WAKE_O
);
	localparam int WW = bbp_pkg::WAKE_W;
	localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_CYC - 1);

	typedef struct packed {
		bbp_pkg::bbp_sst_t st; // sync sequencer
		logic [7:0] mode; // mode-select value
		logic [7:0] mask; // direction, one = output
		logic pd; // pull-down on flush input
		logic [15:0] baud; // divisor
		logic [7:0] pout; // pin output latch
		logic pend; // async byte waiting for tick
		logic [7:0] pbyte; // byte taken from host
		logic rx_rdy;
		logic tx_valid;
		logic [7:0] tx_data;
		logic rd_n; // sample strobe, idles low
		logic wr_n; // update strobe, idles high
		logic fl_q; // flush input last cycle
		logic [WW-1:0] wcnt; // low time while suspended
		logic woke; // wake already sent this pulse
		logic flush;
		logic wake;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awrdy;
		logic wrdy;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bbp_st_t;
	bbp_st_t s_r, s_nxt;

	bbp_tick_if tif ();

	bbp_baud_gen u_baud (
		.CLK_SYS_I(CLK_SYS_I),
		.RST_I(RST_I),
		.tif(tif)
	);

	////////////////////////////////////////////////////////////////////
	// register index from byte address, 3 = unmapped
	function automatic logic [1:0] reg_sel(input logic [7:0] a);
		unique case (a)
			bbp_pkg::OFS_CTRL: reg_sel = 2'h0;
			bbp_pkg::OFS_BAUD: reg_sel = 2'h1;
			bbp_pkg::OFS_STAT: reg_sel = 2'h2;
			default: reg_sel = 2'h3;
		endcase
	endfunction : reg_sel

	// byte-lane merge of a write
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	logic is_async, is_sync, take, fall, wr_ctrl;
	logic [31:0] ctrl_v, stat_v, wv;

	// decoded modes and current register images
	always_comb begin
		is_async = (s_r.mode == bbp_pkg::MODE_ASYNC);
		is_sync = (s_r.mode == bbp_pkg::MODE_SYNC);
		take = RX_VALID_I && s_r.rx_rdy;
		fall = s_r.fl_q && !FLUSH_OR_WAKE_N_I;
		ctrl_v = '0;
		ctrl_v[bbp_pkg::CTRL_MODE_LSB +: 8] = s_r.mode;
		ctrl_v[bbp_pkg::CTRL_MASK_LSB +: 8] = s_r.mask;
		ctrl_v[bbp_pkg::CTRL_PD_BIT] = s_r.pd;
		stat_v = '0;
		stat_v[bbp_pkg::STAT_PIN_LSB +: 8] = PIN_I;
		stat_v[bbp_pkg::STAT_OUT_LSB +: 8] = s_r.pout;
		stat_v[bbp_pkg::STAT_PEND_BIT] = s_r.pend;
		stat_v[bbp_pkg::STAT_BUSY_BIT] = (s_r.st != bbp_pkg::ST_IDLE);
		wr_ctrl = s_r.aw_got && s_r.w_got && !s_r.bvalid &&
			(reg_sel(s_r.awaddr) == 2'h0);
	end

	////////////////////////////////////////////////////////////////////
	// next state of the whole block
	always_comb begin
		s_nxt = s_r;
		wv = '0;
		s_nxt.rd_n = 1'b0; // sample strobe rests active
		s_nxt.wr_n = 1'b1;
		s_nxt.flush = 1'b0;
		s_nxt.wake = 1'b0;
		s_nxt.fl_q = FLUSH_OR_WAKE_N_I;
		if (s_r.tx_valid && TX_READY_I) begin
			s_nxt.tx_valid = 1'b0;
		end
		// asynchronous variant: tick paces both directions
		if (is_async) begin
			if (take) begin
				s_nxt.pend = 1'b1;
				s_nxt.pbyte = RX_DATA_I;
			end
			if (tif.tick && s_r.pend) begin
				s_nxt.pout = s_r.pbyte;
				s_nxt.pend = 1'b0;
				s_nxt.wr_n = 1'b0;
			end
			if (tif.tick && !s_r.tx_valid) begin
				s_nxt.tx_data = PIN_I;
				s_nxt.tx_valid = 1'b1;
				s_nxt.rd_n = 1'b1;
			end
		end
		// synchronous variant: one write cycle per host byte
		unique case (s_r.st)
			bbp_pkg::ST_IDLE: begin
				if (is_sync && take) begin
					s_nxt.pbyte = RX_DATA_I;
					s_nxt.tx_data = PIN_I;
					s_nxt.tx_valid = 1'b1;
					s_nxt.rd_n = 1'b1;
					s_nxt.st = bbp_pkg::ST_SAMPLE;
				end
			end
			bbp_pkg::ST_SAMPLE: begin
				s_nxt.pout = s_r.pbyte;
				s_nxt.st = bbp_pkg::ST_DRIVE;
			end
			bbp_pkg::ST_DRIVE: begin
				// one clock of data setup has passed
				s_nxt.wr_n = 1'b0;
				s_nxt.st = bbp_pkg::ST_STROBE;
			end
			bbp_pkg::ST_STROBE: begin
				s_nxt.st = bbp_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.st = bbp_pkg::ST_IDLE;
			end
		endcase
		// flush and wake from the shared input
		if (fall && (is_async || is_sync) && !SUSPENDED_I) begin
			s_nxt.flush = 1'b1;
		end
		if (SUSPENDED_I && !FLUSH_OR_WAKE_N_I) begin
			if (s_r.wcnt != WAKE_LAST) begin
				s_nxt.wcnt = s_r.wcnt + WW'(1);
			end
		end else begin
			s_nxt.wcnt = '0;
			s_nxt.woke = 1'b0;
		end
		// pull-down blocks wake; one pulse per low period
		if (s_r.wcnt == WAKE_LAST && !s_r.woke && !s_r.pd) begin
			s_nxt.wake = 1'b1;
			s_nxt.woke = 1'b1;
		end
		// axi write channels, taken in either order
		if (AWVALID_I && s_r.awrdy) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = AWADDR_I;
		end
		if (WVALID_I && s_r.wrdy) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = WDATA_I;
			s_nxt.wstrb = WSTRB_I;
		end
		if (s_r.bvalid && BREADY_I) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = bbp_pkg::RESP_OKAY;
			unique case (reg_sel(s_r.awaddr))
				2'h0: begin
					// mode-select: new variant and direction
					wv = wmerge(ctrl_v, s_r.wdata, s_r.wstrb);
					s_nxt.mode = wv[bbp_pkg::CTRL_MODE_LSB +: 8];
					s_nxt.mask = wv[bbp_pkg::CTRL_MASK_LSB +: 8];
					s_nxt.pd = wv[bbp_pkg::CTRL_PD_BIT];
					s_nxt.st = bbp_pkg::ST_IDLE;
					s_nxt.pend = 1'b0;
				end
				2'h1: begin
					wv = wmerge({16'h0000, s_r.baud}, s_r.wdata, s_r.wstrb);
					s_nxt.baud = wv[15:0];
				end
				2'h2: begin
					s_nxt.bresp = bbp_pkg::RESP_SLVERR; // read only
				end
				default: begin
					s_nxt.bresp = bbp_pkg::RESP_SLVERR;
				end
			endcase
		end
		// axi read, one outstanding
		if (s_r.rvalid && RREADY_I) begin
			s_nxt.rvalid = 1'b0;
		end
		if (ARVALID_I && s_r.arrdy) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = bbp_pkg::RESP_OKAY;
			unique case (reg_sel(ARADDR_I))
				2'h0: s_nxt.rdata = ctrl_v;
				2'h1: s_nxt.rdata = {16'h0000, s_r.baud};
				2'h2: s_nxt.rdata = stat_v;
				default: begin
					s_nxt.rdata = '0;
					s_nxt.rresp = bbp_pkg::RESP_SLVERR;
				end
			endcase
		end
		// readies: registered so outputs come from flops
		s_nxt.awrdy = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wrdy = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arrdy = !s_nxt.rvalid && !(ARVALID_I && s_r.arrdy);
		// host byte accepted only when a sync cycle can start or no async byte is pending
		if (s_nxt.mode == bbp_pkg::MODE_SYNC) begin
			s_nxt.rx_rdy = (s_nxt.st == bbp_pkg::ST_IDLE) && !take &&
				TX_READY_I && !s_nxt.tx_valid;
		end else if (s_nxt.mode == bbp_pkg::MODE_ASYNC) begin
			s_nxt.rx_rdy = !s_nxt.pend && !take;
		end else begin
			s_nxt.rx_rdy = 1'b0; // off: host data waits
		end
	end

	// state register
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			s_r <= '0;
			s_r.st <= bbp_pkg::ST_IDLE;
			s_r.mode <= bbp_pkg::MODE_OFF;
			s_r.mask <= bbp_pkg::MASK_RST;
			s_r.baud <= bbp_pkg::BAUD_RST;
			s_r.wr_n <= 1'b1;
			s_r.fl_q <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all from flops; pins driven only where mask says output
	assign tif.divisor = s_r.baud;
	assign tif.enable = is_async;
	assign AWREADY_O = s_r.awrdy;
	assign WREADY_O = s_r.wrdy;
	assign BVALID_O = s_r.bvalid;
	assign BRESP_O = s_r.bresp;
	assign ARREADY_O = s_r.arrdy;
	assign RVALID_O = s_r.rvalid;
	assign RDATA_O = s_r.rdata;
	assign RRESP_O = s_r.rresp;
	assign RX_READY_O = s_r.rx_rdy;
	assign TX_VALID_O = s_r.tx_valid;
	assign TX_DATA_O = s_r.tx_data;
	assign PIN_O = s_r.pout;
	assign PIN_OE_O = s_r.mask;
	assign PIN_SAMPLE_STROBE_N_O = s_r.rd_n;
	assign PIN_UPDATE_STROBE_N_O = s_r.wr_n;
	assign FLUSH_O = s_r.flush;
	assign WAKE_O = s_r.wake;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	logic sync_take;
	assign sync_take = take && is_sync && s_r.st == bbp_pkg::ST_IDLE;

	sequence rd_pulse_s;
		PIN_SAMPLE_STROBE_N_O ##1 !PIN_SAMPLE_STROBE_N_O;
	endsequence
	sequence wr_pulse_s;
		!PIN_UPDATE_STROBE_N_O ##1 PIN_UPDATE_STROBE_N_O;
	endsequence

	sync_cycle_order_a: assert property (
		sync_take |=> rd_pulse_s ##1 wr_pulse_s)
		else $error("sync cycle strobe order wrong");
	sync_drive_a: assert property (
		sync_take |-> ##2 (PIN_O == $past(RX_DATA_I, 2)))
		else $error("sync byte not driven two cycles after take");
	sample_first_a: assert property (
		sync_take |=> (TX_VALID_O && TX_DATA_O == $past(PIN_I)))
		else $error("sample not taken before drive");
	sync_room_a: assert property (
		(RX_READY_O && is_sync) |-> ($past(TX_READY_I) && !TX_VALID_O))
		else $error("sync byte accepted without room");
	sync_sample_only_a: assert property (
		(is_sync && $rose(TX_VALID_O)) |-> $past(sync_take))
		else $error("sync sample without a write cycle");
	async_hold_a: assert property (
		(is_async && !(tif.tick && s_r.pend) && !wr_ctrl) |=>
		$stable(PIN_O))
		else $error("async pins changed without byte and tick");
	dir_stable_a: assert property (
		!wr_ctrl |=> $stable(PIN_OE_O))
		else $error("direction changed without mode select");
	flush_edge_a: assert property (
		($fell(FLUSH_OR_WAKE_N_I) && (is_async || is_sync) &&
		!SUSPENDED_I) |=> FLUSH_O)
		else $error("flush not flagged on falling edge");
	no_wake_pd_a: assert property (
		s_r.pd |=> !WAKE_O)
		else $error("wake issued with pull-down enabled");
endmodule : bbp_port
`default_nettype wire

// ===== sim/bbp_pin_partner.sv
// Purpose: external logic on the parallel pins of one channel
// Assumes: far side never drives a bit that the port drives
// Notes: latches the bus when the update strobe is released
`timescale 1ns/100ps
`default_nettype none
module bbp_pin_partner (
	input wire logic [7:0] drv_i, // port output latch
	input wire logic [7:0] oe_i, // port direction, 1 = port drives
	input wire logic [7:0] ext_i, // level the far side puts on inputs
	input wire logic upd_n_i, // update strobe, active low
	output logic [7:0] pin_o, // resolved wire level
	output logic [7:0] got_o // bus seen at strobe release
);
	////////////////////////////////////////////////////////////////////
	// one driver per bit, so the wire never floats or fights
	assign pin_o = (drv_i & oe_i) | (ext_i & ~oe_i);
	// clocked by port accesses, which is what the strobe is for
	always_ff @(posedge upd_n_i) begin
		got_o <= pin_o;
	end
endmodule : bbp_pin_partner
`default_nettype wire

// ===== sim/bbp_port_bench.sv
// Purpose: self-checking bench of one bit-bang port channel
// Assumes: far side obeys the direction mask
// Notes: wake hold count shortened to keep the run brief
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("wrong value at %0t: got %h want %h", $time, g, e); \
	end \
end
module bbp_port_bench;
	localparam int unsigned WAKE_N = 20; // short wake hold
	// 250 ns low, whole 40 ns cycles since pins move on clock edges
	localparam int unsigned FLUSH_LOW = (250 + 39) / 40;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [7:0] rx_data = 8'h00, tx_data, pin_in, pin_out, pin_oe, got;
	logic rx_valid = 1'b0, tx_ready = 1'b1, rx_ready, tx_valid;
	logic smp_n, upd_n, flush, wake;
	logic flush_wake_n = 1'b1, susp = 1'b0;
	logic [7:0] ext = 8'h3c; // far side level on input bits
	logic [7:0] msk [2] = '{8'h0f, 8'h00}; // mixed, then all inputs
	logic [7:0] rxq [$]; // samples handed to the host
	int failures = 0, n_compared = 0;
	int n_smp = 0, n_upd = 0, n_fl = 0, n_wk = 0, s0, u0, f0;
	////////////////////////////////////////////////////////////////////
	bbp_port #(.WAKE_CYC(WAKE_N)) i_dut (
		.CLK_SYS_I(clk), .RST_I(rst),
		.AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
		.BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
		.ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
		.RVALID_O(rvalid), .RREADY_I(rready),
		.RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready),
		.TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
		.PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_O(pin_oe),
		.PIN_SAMPLE_STROBE_N_O(smp_n), .PIN_UPDATE_STROBE_N_O(upd_n),
		.FLUSH_OR_WAKE_N_I(flush_wake_n), .SUSPENDED_I(susp),
		.FLUSH_O(flush), .WAKE_O(wake)
	);
	bbp_pin_partner i_far (
		.drv_i(pin_out), .oe_i(pin_oe), .ext_i(ext), .upd_n_i(upd_n),
		.pin_o(pin_in), .got_o(got)
	);
	////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end
	// strobe, pulse and to-host traffic monitor; host stalls only in the no-room test
	always @(posedge clk) begin
		if (smp_n === 1'b1) n_smp++;
		if (upd_n === 1'b0) n_upd++;
		if (flush === 1'b1) n_fl++;
		if (wake === 1'b1) n_wk++;
		if (tx_valid === 1'b1 && tx_ready) rxq.push_back(tx_data);
	end
	////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (failures == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	// register write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic b;
		b = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				b = 1'b1;
				bready <= 1'b0;
				`CHK(bresp, er)
			end
		end
	endtask : wr
	// register read with expected data and answer code
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic b;
		b = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!b) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				b = 1'b1;
				rready <= 1'b0;
				`CHK(rdata, ed)
				`CHK(rresp, er)
			end
		end
	endtask : rd
	// one byte from the host pipe, held until taken
	task automatic send(input logic [7:0] d);
		logic b;
		b = 1'b0;
		@(posedge clk);
		rx_data <= d;
		rx_valid <= 1'b1;
		while (!b) begin
			@(posedge clk);
			b = (rx_ready === 1'b1);
		end
		rx_valid <= 1'b0;
	endtask : send
	// low pulse on the flush/wake input
	task automatic hold_low(input int n);
		@(posedge clk);
		flush_wake_n <= 1'b0;
		repeat (n) @(posedge clk);
		flush_wake_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : hold_low
	////////////////////////////////////////////////////////////////////
	// hang guard, far above the few hundred cycles the tests take
	initial begin
		#200000;
		failures++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		// reset values, unmapped and read-only places
		rd(bbp_pkg::OFS_BAUD, {16'h0, bbp_pkg::BAUD_RST}, 2'h0);
		rd(bbp_pkg::OFS_CTRL, 32'h0, bbp_pkg::RESP_OKAY);
		rd(8'h0c, 32'h0, bbp_pkg::RESP_SLVERR);
		wr(bbp_pkg::OFS_STAT, 32'h1, bbp_pkg::RESP_SLVERR);
		`CHK(rx_ready, 1'b0)
		// synchronous, all outputs: samples lag by one byte
		wr(bbp_pkg::OFS_CTRL, 32'h0000ff04, bbp_pkg::RESP_OKAY);
		rxq.delete();
		s0 = n_smp;
		send(8'h55);
		send(8'haa);
		send(8'haa);
		repeat (6) @(posedge clk);
		`CHK(pin_oe, 8'hff)
		`CHK(rxq[0], 8'hff & 8'h00)
		`CHK(rxq[1], 8'h55)
		`CHK(rxq[2], 8'haa)
		`CHK(got, 8'haa)
		`CHK(pin_out, 8'haa)
		`CHK(n_smp - s0, 3)
		// mixed and all-input masks still need host writes
		foreach (msk[i]) begin
			wr(bbp_pkg::OFS_CTRL, {16'h0, msk[i], bbp_pkg::MODE_SYNC},
				bbp_pkg::RESP_OKAY);
			rxq.delete();
			s0 = n_smp;
			u0 = n_upd;
			send(8'h81);
			send(8'h81);
			repeat (6) @(posedge clk);
			`CHK(pin_oe, msk[i])
			`CHK(rxq[1], (8'h81 & msk[i]) | (ext & ~msk[i]))
			`CHK(n_smp - s0, 2)
			`CHK(n_upd - u0, 2)
		end
		// no room toward the host: no cycle starts
		tx_ready <= 1'b0;
		s0 = n_smp;
		fork
			send(8'h42);
			begin
				repeat (8) @(posedge clk);
				`CHK(rx_ready, 1'b0)
				`CHK(n_smp - s0, 0)
				tx_ready <= 1'b1;
			end
		join
		repeat (6) @(posedge clk);
		`CHK(n_smp - s0, 1)
		// asynchronous, tick every four cycles
		wr(bbp_pkg::OFS_BAUD, 32'h4, bbp_pkg::RESP_OKAY);
		rd(bbp_pkg::OFS_BAUD, 32'h4, bbp_pkg::RESP_OKAY);
		wr(bbp_pkg::OFS_CTRL, 32'h0000ff01, bbp_pkg::RESP_OKAY);
		u0 = n_upd;
		repeat (8) @(posedge clk);
		`CHK(n_upd - u0, 0)
		send(8'ha5);
		repeat (6) @(posedge clk);
		`CHK(pin_out, 8'ha5)
		`CHK(got, 8'ha5)
		s0 = n_smp;
		repeat (20) @(posedge clk);
		`CHK(n_smp - s0, 5)
		`CHK(n_upd - u0, 1)
		`CHK(rxq[$], 8'ha5)
		// flush once sending has stopped, then wake while suspended
		f0 = n_fl;
		hold_low(FLUSH_LOW);
		`CHK(n_fl - f0, 1)
		susp <= 1'b1;
		hold_low(WAKE_N + 5);
		`CHK(n_wk, 1)
		`CHK(n_fl - f0, 1)
		wr(bbp_pkg::OFS_CTRL, 32'h0001ff01, bbp_pkg::RESP_OKAY);
		hold_low(WAKE_N + 5);
		`CHK(n_wk, 1)
		susp <= 1'b0;
		wr(bbp_pkg::OFS_CTRL, 32'h0, bbp_pkg::RESP_OKAY);
		`CHK(rx_ready, 1'b0)
		final_report();
	end
endmodule : bbp_port_bench
`default_nettype wire
